// file: rtl/pocs_pkg.sv
// Purpose: constants and types for the power-on configuration sequencer
// Assumes: 40 MHz free-running internal oscillator as clock
// Notes:   all timing counts derive from times in their own units
package pocs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ             = 40;
  localparam int unsigned CONFIG_TIME_US      = 450;
  localparam int unsigned IO_SETTLE_US        = 2;
  localparam int unsigned CONFIG_CYCLES       = CONFIG_TIME_US * CLK_MHZ;
  localparam int unsigned IO_SETTLE_CYCLES    = IO_SETTLE_US * CLK_MHZ;
  localparam int unsigned CNT_W               = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO       = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE        = 16'h0001;
  localparam logic [CNT_W-1:0] IO_SETTLE_CNT  = CNT_W'(IO_SETTLE_CYCLES);

  // ****************************************
  // Synchroniser and state
  // ****************************************
  localparam int unsigned SYNC_W = 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;

  typedef enum logic [2:0] {
    POCS_OFF      = 3'b000,
    POCS_DOWNLOAD = 3'b001,
    POCS_WAIT_IO  = 3'b010,
    POCS_IO_SETTLE = 3'b011,
    POCS_CLEAR    = 3'b100,
    POCS_USER     = 3'b101,
    POCS_LOCKED   = 3'b110
  } pocs_state_t;

endpackage : pocs_pkg

// file: rtl/pocs_sequencer.sv
// Purpose: power-on reset and configuration sequencer
// Assumes: comparator flags are asynchronous; clock is the internal oscillator
// Notes:   analog thresholds live in the comparators, not here
//          config time is the slow-device bound; a faster part only waits longer
//          option enables are straps, read without synchronisers
//          the zero hold before a Z restart is the board's duty, not checked here
// Operation
// (R01) Tri-state pins with pull-ups until user
// (R02) Start download at core start threshold
// (R03) Finish within one configuration time
// (R04) User mode waits for all I/O banks
// (R05) Late I/O: user mode 2 us later
// (R06) Hand pins to user logic
// (R07) Non-Z: core sag resets SRAM, tri-states
// (R08) Non-Z: restart download on core recovery
// (R09) Z: no monitoring in user mode
// (R10) Z: restart when core rises from zero
// (R11) Clear registers before releasing tri-states
// (R12) Clear pin holds clears past release
// (R13) Output-enable pin holds tri-states
// (R14) Synchronised flags, oscillator-counted delays
`timescale 1ns/10ps
module pocs_sequencer #(
  parameter int unsigned CONFIG_CYCLES = pocs_pkg::CONFIG_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic z_variant,
  input  wire logic core_above_start,
  input  wire logic core_above_sag,
  input  wire logic core_at_zero,
  input  wire logic io_banks_good,
  input  wire logic dev_clear_enable,
  input  wire logic device_clear_pin_n,
  input  wire logic device_output_enable_pin_enable,
  input  wire logic device_output_enable_pin,
  input  wire logic download_done,
  output logic      download_start,
  output logic      sram_reset,
  output logic      io_tristate,
  output logic      io_pullup_en,
  output logic      user_reg_clear,
  output logic      user_mode
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    // Three-stage synchronisers
    logic [pocs_pkg::SYNC_W-1:0] start_s;
    logic [pocs_pkg::SYNC_W-1:0] sag_s;
    logic [pocs_pkg::SYNC_W-1:0] zero_s;
    logic [pocs_pkg::SYNC_W-1:0] io_s;
    logic [pocs_pkg::SYNC_W-1:0] clrn_s;
    logic [pocs_pkg::SYNC_W-1:0] oe_s;
    logic [pocs_pkg::SYNC_W-1:0] dl_s;
    // Filtered levels
    logic                        start_f;
    logic                        sag_f;
    logic                        zero_f;
    logic                        io_f;
    logic                        clrn_f;
    logic                        oe_f;
    logic                        dl_f;
    // Sequence and outputs
    pocs_pkg::pocs_state_t       state;
    logic [pocs_pkg::CNT_W-1:0]  cnt;
    logic                        start_pulse;
    logic                        sram_rst;
    logic                        pin_hold;
    logic                        clr;
    logic                        user;
  } pocs_regs_t;

  pocs_regs_t r_q;
  pocs_regs_t r_d;

  localparam logic [pocs_pkg::CNT_W-1:0] CFG_CNT = pocs_pkg::CNT_W'(CONFIG_CYCLES);

  // Safe state: pins held, SRAM and registers cleared
  localparam pocs_regs_t POCS_REGS_RST = '{
    start_s:     pocs_pkg::SYNC_RST,
    sag_s:       pocs_pkg::SYNC_RST,
    zero_s:      pocs_pkg::SYNC_RST,
    io_s:        pocs_pkg::SYNC_RST,
    clrn_s:      pocs_pkg::SYNC_RST,
    oe_s:        pocs_pkg::SYNC_RST,
    dl_s:        pocs_pkg::SYNC_RST,
    start_f:     1'b0,
    sag_f:       1'b0,
    zero_f:      1'b0,
    io_f:        1'b0,
    clrn_f:      1'b0,
    oe_f:        1'b0,
    dl_f:        1'b0,
    state:       pocs_pkg::POCS_OFF,
    cnt:         pocs_pkg::CNT_ZERO,
    start_pulse: 1'b0,
    sram_rst:    1'b1,
    pin_hold:    1'b1,
    clr:         1'b1,
    user:        1'b0
  };

  // ****************************************
  // Helpers
  // ****************************************
  // Filtered level: changes only when stages two and three agree
  function automatic logic pocs_filt(
    input logic [pocs_pkg::SYNC_W-1:0] s,
    input logic                        prev
  );
    if (s[1] == s[2]) begin
      pocs_filt = s[2];
    end else begin
      pocs_filt = prev;
    end
  endfunction : pocs_filt

  function automatic logic [pocs_pkg::SYNC_W-1:0] pocs_shift(
    input logic [pocs_pkg::SYNC_W-1:0] s,
    input logic                        d
  );
    pocs_shift = {s[1:0], d};
  endfunction : pocs_shift

  // Timer reached its end; a zero count counts as expired too
  function automatic logic pocs_expired(
    input logic [pocs_pkg::CNT_W-1:0] c
  );
    if (c <= pocs_pkg::CNT_ONE) begin
      pocs_expired = 1'b1;
    end else begin
      pocs_expired = 1'b0;
    end
  endfunction : pocs_expired

  // Optional pin keeps a hold asserted; with the option off the hold drops
  function automatic logic pocs_hold(
    input logic enable,
    input logic released
  );
    pocs_hold = enable && !released;
  endfunction : pocs_hold

  // States in which a non-Z core sag aborts the sequence
  function automatic logic pocs_watched(
    input pocs_pkg::pocs_state_t s
  );
    case (s)
      pocs_pkg::POCS_DOWNLOAD,
      pocs_pkg::POCS_WAIT_IO,
      pocs_pkg::POCS_IO_SETTLE,
      pocs_pkg::POCS_CLEAR,
      pocs_pkg::POCS_USER: begin
        pocs_watched = 1'b1;
      end
      default: begin
        pocs_watched = 1'b0;
      end
    endcase
  endfunction : pocs_watched

  // Back to the safe state: SRAM reset, pins held, registers cleared
  function automatic pocs_regs_t pocs_enter_off(
    input pocs_regs_t r
  );
    pocs_enter_off             = r;
    pocs_enter_off.state       = pocs_pkg::POCS_OFF;
    pocs_enter_off.start_pulse = 1'b0;
    pocs_enter_off.sram_rst    = 1'b1;
    pocs_enter_off.pin_hold    = 1'b1;
    pocs_enter_off.clr         = 1'b1;
    pocs_enter_off.user        = 1'b0;
  endfunction : pocs_enter_off

  // Leave the safe state: one start strobe, SRAM out of reset, timer armed
  function automatic pocs_regs_t pocs_start_download(
    input pocs_regs_t                 r,
    input logic [pocs_pkg::CNT_W-1:0] cycles
  );
    pocs_start_download             = r;
    pocs_start_download.state       = pocs_pkg::POCS_DOWNLOAD;
    pocs_start_download.start_pulse = 1'b1;
    pocs_start_download.sram_rst    = 1'b0;
    pocs_start_download.cnt         = cycles;
  endfunction : pocs_start_download

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_d             = r_q;
    r_d.start_pulse = 1'b0;
    // Supply flags and pins cross in from the analog side
    r_d.start_s = pocs_shift(r_q.start_s, core_above_start); // R14
    r_d.sag_s   = pocs_shift(r_q.sag_s, core_above_sag);
    r_d.zero_s  = pocs_shift(r_q.zero_s, core_at_zero);
    r_d.io_s    = pocs_shift(r_q.io_s, io_banks_good);
    r_d.clrn_s  = pocs_shift(r_q.clrn_s, device_clear_pin_n);
    r_d.oe_s    = pocs_shift(r_q.oe_s, device_output_enable_pin);
    r_d.dl_s    = pocs_shift(r_q.dl_s, download_done);
    r_d.start_f = pocs_filt(r_q.start_s, r_q.start_f); // R14
    r_d.sag_f   = pocs_filt(r_q.sag_s, r_q.sag_f);
    r_d.zero_f  = pocs_filt(r_q.zero_s, r_q.zero_f);
    r_d.io_f    = pocs_filt(r_q.io_s, r_q.io_f);
    r_d.clrn_f  = pocs_filt(r_q.clrn_s, r_q.clrn_f);
    r_d.oe_f    = pocs_filt(r_q.oe_s, r_q.oe_f);
    r_d.dl_f    = pocs_filt(r_q.dl_s, r_q.dl_f);
    // One down counter serves both timed waits
    if (r_q.cnt != pocs_pkg::CNT_ZERO) begin
      r_d.cnt = r_q.cnt - pocs_pkg::CNT_ONE; // R14
    end
    case (r_q.state)
      pocs_pkg::POCS_OFF: begin
        r_d.pin_hold = 1'b1; // R01
        r_d.sram_rst = 1'b1;
        r_d.clr      = 1'b1;
        r_d.user     = 1'b0;
        if (r_q.start_f) begin
          r_d = pocs_start_download(r_d, CFG_CNT); // R02 R03
        end
      end

      pocs_pkg::POCS_DOWNLOAD: begin
        // Download and timer both must end; the timer sets the shortest wait
        if (r_q.dl_f && pocs_expired(r_q.cnt)) begin
          r_d.state = pocs_pkg::POCS_WAIT_IO; // R03
        end
      end

      pocs_pkg::POCS_WAIT_IO: begin
        if (r_q.io_f) begin
          r_d.state = pocs_pkg::POCS_CLEAR; // R04
        end else begin
          // Armed here so a bank rising next cycle still waits the full delay
          r_d.state = pocs_pkg::POCS_IO_SETTLE;
          r_d.cnt   = pocs_pkg::IO_SETTLE_CNT; // R05
        end
      end

      pocs_pkg::POCS_IO_SETTLE: begin
        if (!r_q.io_f) begin
          r_d.cnt = pocs_pkg::IO_SETTLE_CNT; // R05
        end else if (pocs_expired(r_q.cnt)) begin
          r_d.state = pocs_pkg::POCS_CLEAR; // R04
        end
      end

      pocs_pkg::POCS_CLEAR: begin
        // Registers leave clear one cycle before pins leave tri-state
        r_d.clr   = pocs_hold(dev_clear_enable, r_q.clrn_f); // R11 R12
        r_d.state = pocs_pkg::POCS_USER;
      end

      pocs_pkg::POCS_USER: begin
        r_d.user     = 1'b1;
        r_d.pin_hold = pocs_hold(device_output_enable_pin_enable, r_q.oe_f); // R06 R13
        r_d.clr      = pocs_hold(dev_clear_enable, r_q.clrn_f); // R12
        if (z_variant) begin
          r_d.state = pocs_pkg::POCS_LOCKED; // R09
        end
      end

      pocs_pkg::POCS_LOCKED: begin
        // Supplies ignored here; only a full collapse to zero restarts
        r_d.pin_hold = pocs_hold(device_output_enable_pin_enable, r_q.oe_f); // R13
        r_d.clr      = pocs_hold(dev_clear_enable, r_q.clrn_f); // R12
        if (r_q.zero_f) begin
          r_d = pocs_enter_off(r_d); // R10
        end
      end

      default: begin
        r_d = pocs_enter_off(r_d);
      end
    endcase
    // Non-Z sag aborts a download or user mode alike
    if (!z_variant && !r_q.sag_f && pocs_watched(r_q.state)) begin
      r_d = pocs_enter_off(r_d); // R07 R08
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      r_q <= POCS_REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign download_start = r_q.start_pulse;
  assign sram_reset     = r_q.sram_rst;
  assign io_tristate    = r_q.pin_hold;
  assign io_pullup_en   = r_q.pin_hold; // R01
  assign user_reg_clear = r_q.clr;
  assign user_mode      = r_q.user;

endmodule : pocs_sequencer

// file: dv/pocs_chk.sv
// Purpose: port-level checks of the sequencer
// Assumes: flags pass a 3-flop synchroniser
// Notes: windows of 6 cycles cover that latency
`timescale 1ns/10ps
module pocs_chk #(
  parameter int unsigned CONFIG_CYCLES = 50
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic z_variant,
  input wire logic core_above_start,
  input wire logic core_above_sag,
  input wire logic core_at_zero,
  input wire logic io_banks_good,
  input wire logic dev_clear_enable,
  input wire logic device_clear_pin_n,
  input wire logic device_output_enable_pin_enable,
  input wire logic device_output_enable_pin,
  input wire logic download_done,
  input wire logic download_start,
  input wire logic sram_reset,
  input wire logic io_tristate,
  input wire logic io_pullup_en,
  input wire logic user_reg_clear,
  input wire logic user_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_pull; io_pullup_en == io_tristate; endproperty
  a_pull: assert property (p_pull) else $error("pullup");
  property p_tri; !user_mode |-> io_tristate; endproperty
  a_tri: assert property (p_tri) else $error("tristate");
  property p_pulse; download_start |=> !download_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse");
  property p_gate; $rose(user_mode) |-> $past(io_banks_good, 6); endproperty
  a_gate: assert property (p_gate) else $error("io gate");
  property p_order; $rose(user_mode) && !dev_clear_enable |-> $past(!user_reg_clear && io_tristate);
  endproperty
  a_order: assert property (p_order) else $error("clear order");
  property p_give; $rose(user_mode) && !device_output_enable_pin_enable |-> !io_tristate; endproperty
  a_give: assert property (p_give) else $error("release");
  property p_brown; (!z_variant && !core_above_sag)[*6] |-> sram_reset && !user_mode; endproperty
  a_brown: assert property (p_brown) else $error("brownout");
  property p_zkeep; (z_variant && user_mode && !core_at_zero)[*6] |=> user_mode; endproperty
  a_zkeep: assert property (p_zkeep) else $error("z user");
  property p_oe; (user_mode && device_output_enable_pin_enable && !device_output_enable_pin)[*6] |-> io_tristate;
  endproperty
  a_oe: assert property (p_oe) else $error("oe hold");
  property p_clr; (user_mode && dev_clear_enable && !device_clear_pin_n)[*6] |-> user_reg_clear;
  endproperty
  a_clr: assert property (p_clr) else $error("clear hold");
endmodule : pocs_chk

// file: dv/pocs_flash_model.sv
// Purpose: flash store answering a download after dly cycles
// Assumes: dly of at least 1
// Notes: done drops on reset or a new start
`timescale 1ns/10ps
module pocs_flash_model (
  input  wire logic clock,
  input  wire logic download_start,
  input  wire logic sram_reset,
  input  wire logic [31:0] dly,
  output logic             download_done
);
  int n = 0;
  always @(posedge clock) begin
    if (download_start) n <= dly; else if (n > 1) n <= n - 1;
    download_done <= !sram_reset && !download_start && (n == 1 || download_done);
  end
endmodule : pocs_flash_model

// file: dv/tb_power_on_config_sequencer.sv
// Purpose: self-checking bench of the sequencer
// Assumes: shortened configuration count
// Notes: entry delays are checked as windows
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_power_on_config_sequencer;
  localparam int CFG = 50;
  logic clock, rst, z_variant, core_above_start, core_above_sag, core_at_zero, io_banks_good;
  logic dev_clear_enable, device_clear_pin_n, device_output_enable_pin_enable, device_output_enable_pin, um_q;
  logic download_done, download_start, sram_reset, io_tristate, io_pullup_en, user_reg_clear;
  logic user_mode;
  int dly = 1, errors = 0, check_count = 0, cyc = 0, t0 = 0, lo_q[$], hi_q[$];
  pocs_sequencer #(.CONFIG_CYCLES(CFG)) i_pocs_sequencer (
    .clock(clock), .rst(rst), .z_variant(z_variant), .core_above_start(core_above_start),
    .core_above_sag(core_above_sag), .core_at_zero(core_at_zero),
    .io_banks_good(io_banks_good), .dev_clear_enable(dev_clear_enable),
    .device_clear_pin_n(device_clear_pin_n), .device_output_enable_pin_enable(device_output_enable_pin_enable),
    .device_output_enable_pin(device_output_enable_pin), .download_done(download_done),
    .download_start(download_start), .sram_reset(sram_reset), .io_tristate(io_tristate),
    .io_pullup_en(io_pullup_en), .user_reg_clear(user_reg_clear), .user_mode(user_mode));
  pocs_flash_model i_pocs_flash_model (.clock(clock), .download_start(download_start),
    .sram_reset(sram_reset), .dly(dly), .download_done(download_done));
  initial begin clock = 0; forever #12.5 clock = ~clock; end
  task stop_test;
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    cyc <= cyc + 1;
    um_q <= user_mode;
    if (user_mode === 1'b1 && um_q === 1'b0 && lo_q.size() > 0) begin
      `CHK("entry", 1'b1, (cyc - t0 >= lo_q[0]) && (cyc - t0 <= hi_q[0]))
      void'(lo_q.pop_front());
      void'(hi_q.pop_front());
    end
  end
  task automatic go(input logic zv, input logic late);
    int d;
    d = $urandom_range(2 * CFG, 1);
    @(posedge clock);
    {dly, z_variant, core_above_start, core_above_sag} <= {d, zv, 2'h3};
    {core_at_zero, io_banks_good} <= {1'b0, !late};
    if (!zv) {device_clear_pin_n, device_output_enable_pin} <= 2'($urandom());
    t0 = cyc;
    if (late) begin
      repeat (2 * CFG + 40) @(posedge clock);
      io_banks_good <= 1'b1;
      t0 = cyc;
      lo_q.push_back(int'(pocs_pkg::IO_SETTLE_CYCLES));
      hi_q.push_back(int'(pocs_pkg::IO_SETTLE_CYCLES) + 12);
    end else begin
      lo_q.push_back(CFG);
      hi_q.push_back((d > CFG ? d : CFG) + 16);
    end
    for (int i = 0; i < 3000 && user_mode !== 1'b1; i++) @(posedge clock);
    `CHK("user_mode", 1'b1, user_mode)
  endtask : go
  task automatic down;
    @(posedge clock);
    {core_above_start, core_above_sag, io_banks_good} <= 3'h0;
    repeat (12) @(posedge clock);
    `CHK("sram_reset", 1'b1, sram_reset)
  endtask : down
  initial begin
    {z_variant, core_above_start, core_above_sag, io_banks_good, dev_clear_enable} = 5'h00;
    {device_output_enable_pin_enable, device_output_enable_pin} = 2'h0;
    {core_at_zero, device_clear_pin_n, rst} = 3'h7;
    void'($urandom(34593));
    repeat (20) @(posedge clock);
    `CHK("pullup", 1'b1, io_pullup_en)
    rst <= 1'b0;
    go(0, 0);
    down();
    go(0, 0);
    down();
    go(0, 1);
    down();
    go(1, 0);
    {core_above_sag, core_above_start} <= 2'h0;
    repeat (20) @(posedge clock);
    `CHK("user_mode", 1'b1, user_mode)
    {core_at_zero, device_output_enable_pin_enable, dev_clear_enable, device_clear_pin_n} <= 4'hE;
    device_output_enable_pin <= 1'b0;
    // Core held at zero for 10 us before the Z restart
    repeat (400) @(posedge clock);
    go(1, 0);
    repeat (10) @(posedge clock);
    `CHK("io_tristate", 1'b1, io_tristate)
    device_output_enable_pin <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("io_tristate", 1'b0, io_tristate)
    `CHK("user_reg_clear", 1'b1, user_reg_clear)
    device_clear_pin_n <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("user_reg_clear", 1'b0, user_reg_clear)
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule : tb_power_on_config_sequencer
bind pocs_sequencer pocs_chk #(.CONFIG_CYCLES(CONFIG_CYCLES)) i_pocs_chk (
  .clock(clock), .rst(rst), .z_variant(z_variant), .core_above_start(core_above_start),
  .core_above_sag(core_above_sag), .core_at_zero(core_at_zero),
  .io_banks_good(io_banks_good), .dev_clear_enable(dev_clear_enable),
  .device_clear_pin_n(device_clear_pin_n), .device_output_enable_pin_enable(device_output_enable_pin_enable),
  .device_output_enable_pin(device_output_enable_pin), .download_done(download_done),
  .download_start(download_start), .sram_reset(sram_reset), .io_tristate(io_tristate),
  .io_pullup_en(io_pullup_en), .user_reg_clear(user_reg_clear), .user_mode(user_mode));
